//--- rtl/flash_defs.svh
// constants of the serial flash command engine
// How it works
// - dual-output read: opcode, address, dummy on line zero
// - dual bytes go out as bit pairs, high first
// - read pointer increments, wraps to zero after top
// - dual I/O read: address and dummy on both lines
// - dual address: odd bits line one, even zero
// - chip enable high ends the output stream
// - only whole program bytes kept, partial dropped
// - beyond 256 bytes, only last 256 kept
// - program column wraps within the same page
// - program into protected area is ignored
// - sector erase clears addressed 4 KByte sector
// - block erase clears 64 KByte block unless protected
// - sector erase into protected area is ignored
// - chip erase ignored when any area protected
// - erase starts at deselect, then runs self-timed
// - program runs self-timed after deselect, host polls
// - status readable anytime, repeats every eight clocks
// - write enable sets latch when not busy; writes need latch set
// - write-status completion clears write enable latch
// - write disable clears the write enable latch
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

`define OPC_READ_DUAL 8'h3B
`define OPC_READ_DUALIO 8'hBB
`define OPC_PROGRAM 8'h02
`define OPC_SECTOR_ERASE_A 8'h20
`define OPC_SECTOR_ERASE_B 8'hD7
`define OPC_BLOCK_ERASE 8'hD8
`define OPC_CHIP_ERASE_A 8'h60
`define OPC_CHIP_ERASE_B 8'hC7
`define OPC_READ_STATUS 8'h05
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_WRITE_STATUS 8'h01

`define BYTE_LAST_BIT 5'h07
`define ADDR_LAST_SINGLE 5'h17
`define ADDR_LAST_DUAL 5'h0B
`define DUMMY_LAST_DUAL 5'h03
`define STATUS_LAST_BIT 3'h6
`define PAGE_LAST_COL 8'hFF
`define SECTOR_LOW_ZERO 12'h000
`define BLOCK_LOW_ZERO 16'h0000
`define FIFO_DEPTH 8

`define CLK_MHZ 100
`define PAGE_PROGRAM_TIME_MS 4
`define SECTOR_ERASE_TIME_MS 40
`define BLOCK_ERASE_TIME_MS 80
`define FULL_ERASE_TIME_MS 250
`define US_PER_MS 1000

`endif

//--- rtl/flash_pkg.sv
// types shared by the flash command engine files
`default_nettype none
package flash_pkg;

  typedef enum logic [2:0] {CS_OPC, CS_ADDR, CS_DUMMY, CS_DATA, CS_DOUT, CS_STAT,
    CS_IGNORE} cmd_state_e;
  typedef enum logic [1:0] {OP_IDLE, OP_UNLOAD, OP_WAIT} op_state_e;
  typedef enum logic [1:0] {EK_SECTOR, EK_BLOCK, EK_CHIP} erase_kind_e;

  typedef struct packed {
    logic req;
    erase_kind_e kind;
    logic [18:0] addr;
  } erase_cmd_s;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } prog_word_s;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sck_prev;
    logic ce_prev;
    logic [7:0] prot1;
    logic [7:0] prot2;
    cmd_state_e cst;
    logic [7:0] opc;
    logic [7:0] sr;
    logic [4:0] bits;
    logic dual;
    logic armed;
    logic [23:0] addr;
    logic [18:0] rd_addr;
    logic [7:0] dout;
    logic [2:0] fcnt;
    logic out0;
    logic out1;
    logic oe0;
    logic oe1;
    logic [10:0] page;
    logic [7:0] col;
    logic got_byte;
    logic [255:0][7:0] pbuf;
    logic [255:0] pval;
    op_state_e ost;
    logic [7:0] uidx;
    logic [31:0] timer;
    logic busy;
    logic wel;
    erase_cmd_s ers;
  } engine_state_s;

endpackage
`default_nettype wire

//--- rtl/word_fifo.sv
// parameterised first-in first-out buffer held in flip-flops
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_s;

  fifo_state_s q, n;
  logic full, empty;

  // extra pointer bit tells full from empty without a counter
  assign empty = (q.wr == q.rd);
  assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rd[AW-1:0]];

  // push and pop may happen in the same cycle
  always_comb begin
    n = q;
    if (in_valid && !full) begin
      n.mem[q.wr[AW-1:0]] = in_data;
      n.wr = q.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      n.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

//--- rtl/spi_flash_cmd_engine.sv
// command decoder and write sequencer of the serial flash
`include "flash_defs.svh"
`default_nettype none
module spi_flash_cmd_engine #(
  parameter int unsigned PAGE_PROGRAM_CYCLES = `PAGE_PROGRAM_TIME_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_TIME_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES = `BLOCK_ERASE_TIME_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned FULL_ERASE_CYCLES = `FULL_ERASE_TIME_MS * `US_PER_MS * `CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic chip_en_n,
  input wire logic serial_line_zero_in,
  output logic serial_line_zero_out,
  output logic serial_line_zero_oe,
  input wire logic serial_line_one_in,
  output logic serial_line_one_out,
  output logic serial_line_one_oe,
  input wire logic [7:0] block_protect,
  output logic [18:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output flash_pkg::prog_word_s prog_word,
  output logic prog_valid,
  input wire logic prog_ready,
  output flash_pkg::erase_cmd_s erase_cmd,
  output logic status_busy,
  output logic write_enable_latch
);
  import flash_pkg::*;

  engine_state_s q, n;
  logic sck_s, ce_s, d0, d1, rise, fall, ce_rise, byte_load, byte_store;
  logic fifo_in_valid, fifo_in_ready, rd_b7, rd_b6;
  logic [7:0] in_byte, st_byte;
  logic [23:0] a_new;
  prog_word_s fifo_in_data;

  // only the second synchroniser stage is looked at
  assign sck_s = q.sync2[3];
  assign ce_s = q.sync2[2];
  assign d1 = q.sync2[1];
  assign d0 = q.sync2[0];
  assign rise = sck_s && !q.sck_prev && !ce_s;
  assign fall = !sck_s && q.sck_prev && !ce_s;
  assign ce_rise = ce_s && !q.ce_prev;
  assign in_byte = {q.sr[6:0], d0};
  assign st_byte = {6'h00, q.wel, q.busy};
  assign rd_b7 = mem_rd_data[7];
  assign rd_b6 = mem_rd_data[6];
  assign byte_load = fall && (q.cst == CS_DOUT) && (q.fcnt[1:0] == 2'h0);
  assign byte_store = rise && (q.cst == CS_DATA) && (q.bits == `BYTE_LAST_BIT);
  assign fifo_in_valid = (q.ost == OP_UNLOAD) && q.pval[q.uidx];
  assign fifo_in_data = '{addr: {q.page, q.uidx}, data: q.pbuf[q.uidx]};

  // address capture: one bit per clock, or an odd/even pair in dual mode
  always_comb begin
    if (q.dual) begin
      a_new = {q.addr[21:0], d1, d0};
    end else begin
      a_new = {q.addr[22:0], d0};
    end
  end

  // whole engine: link decode, deselect actions, self-timed sequencer
  always_comb begin
    n = q;
    n.sync1 = {sck, chip_en_n, serial_line_one_in, serial_line_zero_in};
    n.sync2 = q.sync1;
    n.sck_prev = sck_s;
    n.ce_prev = ce_s;
    n.prot1 = block_protect;
    n.prot2 = q.prot1;
    n.ers.req = 1'b0;
    if (ce_s) begin
      n.cst = CS_OPC;
      n.bits = 5'h00;
      n.fcnt = 3'h0;
      n.oe0 = 1'b0;
      n.oe1 = 1'b0;
      n.armed = 1'b0;
    end else if (rise) begin
      n.sr = in_byte;
      case (q.cst)
        CS_OPC: begin
          n.bits = q.bits + 5'h01;
          if (q.bits == `BYTE_LAST_BIT) begin
            n.opc = in_byte;
            n.bits = 5'h00;
            n.dual = 1'b0;
            case (in_byte)
              `OPC_READ_DUAL: n.cst = q.busy ? CS_IGNORE : CS_ADDR;
              `OPC_READ_DUALIO: begin
                n.cst = q.busy ? CS_IGNORE : CS_ADDR;
                n.dual = 1'b1;
              end
              `OPC_PROGRAM, `OPC_SECTOR_ERASE_A, `OPC_SECTOR_ERASE_B,
              `OPC_BLOCK_ERASE: n.cst = (q.busy || !q.wel) ? CS_IGNORE : CS_ADDR;
              // status served even when busy; fall count restarts so bit 7 leads
              `OPC_READ_STATUS: begin
                n.cst = CS_STAT;
                n.fcnt = 3'h0;
              end
              default: begin
                n.cst = CS_IGNORE;
                n.armed = 1'b1;
              end
            endcase
          end
        end
        CS_ADDR: begin
          n.addr = a_new;
          n.bits = q.bits + 5'h01;
          if (q.bits == (q.dual ? `ADDR_LAST_DUAL : `ADDR_LAST_SINGLE)) begin
            n.bits = 5'h00;
            n.rd_addr = a_new[18:0];
            n.col = a_new[7:0];
            n.page = a_new[18:8];
            n.pval = '0;
            n.got_byte = 1'b0;
            n.armed = 1'b1;
            if (q.opc == `OPC_READ_DUAL || q.opc == `OPC_READ_DUALIO) begin
              n.cst = CS_DUMMY;
            end else if (q.opc == `OPC_PROGRAM) begin
              n.cst = CS_DATA;
            end else begin
              n.cst = CS_IGNORE;
            end
          end
        end
        CS_DUMMY: begin
          // dummy line values are not used
          n.bits = q.bits + 5'h01;
          if (q.bits == (q.dual ? `DUMMY_LAST_DUAL : `BYTE_LAST_BIT)) begin
            n.cst = CS_DOUT;
            n.fcnt = 3'h0;
          end
        end
        CS_DATA: begin
          n.bits = q.bits + 5'h01;
          if (q.bits == `BYTE_LAST_BIT) begin
            // whole bytes overwrite, column wraps in page
            n.bits = 5'h00;
            n.pbuf[q.col] = in_byte;
            n.pval[q.col] = 1'b1;
            n.col = q.col + 8'h01;
            n.got_byte = 1'b1;
          end
        end
        default: n.bits = q.bits;
      endcase
    end else if (fall) begin
      n.fcnt = q.fcnt + 3'h1;
      if (q.cst == CS_DOUT) begin
        n.oe0 = 1'b1;
        n.oe1 = 1'b1;
        if (q.fcnt[1:0] == 2'h0) begin
          // fetch a byte, send its top pair, advance pointer
          n.out1 = mem_rd_data[7];
          n.out0 = mem_rd_data[6];
          n.dout = {mem_rd_data[5:0], 2'b00};
          n.rd_addr = q.rd_addr + 19'h00001;
        end else begin
          n.out1 = q.dout[7];
          n.out0 = q.dout[6];
          n.dout = {q.dout[5:0], 2'b00};
        end
      end else if (q.cst == CS_STAT) begin
        // status shifts out on line one, repeating
        n.oe1 = 1'b1;
        n.out1 = st_byte[3'h7 - q.fcnt];
      end
    end

    // self-timed sequencer; pages drain into the buffer before timing
    case (q.ost)
      OP_UNLOAD: begin
        if (!q.pval[q.uidx] || fifo_in_ready) begin
          n.uidx = q.uidx + 8'h01;
          if (q.uidx == `PAGE_LAST_COL) begin
            // program timed after the page is handed over
            n.ost = OP_WAIT;
            n.timer = PAGE_PROGRAM_CYCLES;
          end
        end
      end
      OP_WAIT: begin
        if (q.timer != 32'h0) begin
          n.timer = q.timer - 32'h1;
        end else if (!prog_valid) begin
          // latch cleared when the write finishes
          n.ost = OP_IDLE;
          n.busy = 1'b0;
          n.wel = 1'b0;
        end
      end
      default: n.ost = OP_IDLE;
    endcase

    // deselect runs the command that was completed
    if (ce_rise && q.armed) begin
      case (q.opc)
        // latch set only when idle
        // a write ending in this cycle clears the latch; a busy-time enable must not undo it
        `OPC_WRITE_ENABLE: if (!q.busy) n.wel = 1'b1;
        `OPC_WRITE_DISABLE: n.wel = 1'b0;
        `OPC_WRITE_STATUS: n.wel = 1'b0;
        `OPC_PROGRAM: begin
          // protected page ignored; needs one whole byte
          if (q.got_byte && q.wel && !q.busy && !q.prot2[q.addr[18:16]]) begin
            n.ost = OP_UNLOAD;
            n.uidx = 8'h00;
            n.busy = 1'b1;
          end
        end
        `OPC_SECTOR_ERASE_A, `OPC_SECTOR_ERASE_B: begin
          if (q.wel && !q.busy && !q.prot2[q.addr[18:16]]) begin
            n.ers = '{req: 1'b1, kind: EK_SECTOR, addr: {q.addr[18:12], `SECTOR_LOW_ZERO}};
            n.busy = 1'b1;
            n.ost = OP_WAIT;
            n.timer = SECTOR_ERASE_CYCLES;
          end
        end
        `OPC_BLOCK_ERASE: begin
          if (q.wel && !q.busy && !q.prot2[q.addr[18:16]]) begin
            n.ers = '{req: 1'b1, kind: EK_BLOCK, addr: {q.addr[18:16], `BLOCK_LOW_ZERO}};
            n.busy = 1'b1;
            n.ost = OP_WAIT;
            n.timer = BLOCK_ERASE_CYCLES;
          end
        end
        `OPC_CHIP_ERASE_A, `OPC_CHIP_ERASE_B: begin
          if (q.wel && !q.busy && (q.prot2 == 8'h00)) begin
            n.ers = '{req: 1'b1, kind: EK_CHIP, addr: 19'h00000};
            n.busy = 1'b1;
            n.ost = OP_WAIT;
            n.timer = FULL_ERASE_CYCLES;
          end
        end
        default: n.armed = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // the array side may stall; unloading waits on the buffer
  word_fifo #(.WIDTH($bits(prog_word_s)), .DEPTH(`FIFO_DEPTH)) prog_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_word)
  );

  assign serial_line_zero_out = q.out0;
  assign serial_line_zero_oe = q.oe0;
  assign serial_line_one_out = q.out1;
  assign serial_line_one_oe = q.oe1;
  assign mem_rd_addr = q.rd_addr;
  assign erase_cmd = q.ers;
  assign status_busy = q.busy;
  assign write_enable_latch = q.wel;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_wel_set;
    ce_rise && q.armed && (q.opc == `OPC_WRITE_ENABLE) && !q.busy |=> q.wel;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("write enable did not set latch");

  property p_wel_clear;
    ce_rise && q.armed && (q.opc == `OPC_WRITE_DISABLE) |=> !q.wel;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("write disable left latch");

  property p_write_status_cmd_clear;
    ce_rise && q.armed && (q.opc == `OPC_WRITE_STATUS) |=> !q.wel;
  endproperty
  a_write_status_cmd_clear: assert property (p_write_status_cmd_clear) else $error("write status left latch");

  property p_busy_needs_wel;
    $rose(q.busy) |-> $past(q.wel) && $past(ce_rise);
  endproperty
  a_busy_needs_wel: assert property (p_busy_needs_wel) else $error("write without latch");

  property p_done_clears;
    $fell(q.busy) |-> !q.wel && (q.ost == OP_IDLE);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("latch kept after write");

  property p_chip_prot;
    q.ers.req && (q.ers.kind == EK_CHIP) |-> ($past(q.prot2) == 8'h00);
  endproperty
  a_chip_prot: assert property (p_chip_prot) else $error("chip erase while protected");

  property p_erase_timed;
    q.ers.req |-> q.busy ##1 q.busy [*8];
  endproperty
  a_erase_timed: assert property (p_erase_timed) else $error("erase not self-timed");

  property p_ce_stop;
    ce_s && q.ce_prev |-> !q.oe0 && !q.oe1;
  endproperty
  a_ce_stop: assert property (p_ce_stop) else $error("driving while deselected");

  property p_ptr_inc;
    byte_load |=> (q.rd_addr == $past(q.rd_addr) + 19'h00001);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("read pointer did not advance");

  property p_pair_order;
    byte_load |=> (q.out1 == $past(rd_b7)) && (q.out0 == $past(rd_b6)) && q.oe0 && q.oe1;
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("wrong first bit pair");

  property p_col_wrap;
    byte_store |=> (q.col == $past(q.col) + 8'h01) && (q.page == $past(q.page));
  endproperty
  a_col_wrap: assert property (p_col_wrap) else $error("column left the page");
endmodule
`default_nettype wire

//--- bench/spi_host_model.sv
// serial host model: drives clock, chip enable and both data lines
`default_nettype none
module spi_host_model (
  input wire logic clk_sys,
  output logic sck,
  output logic chip_en_n,
  output logic [1:0] drv,
  output logic [1:0] en,
  input wire logic [1:0] lines
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle: deselected, clock low, lines released
  initial begin
    sck = 1'b0;
    chip_en_n = 1'b1;
    drv = 2'h0;
    en = 2'h0;
  end

  // step n system cycles, then move just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // enable held low for the whole frame
  task automatic select();
    chip_en_n = 1'b0;
    tick(8);
  endtask

  // clock stands low between frames; lines let go with the deselect
  task automatic deselect();
    tick(8);
    chip_en_n = 1'b1;
    en = 2'h0;
    tick(16);
  endtask

  // one 160 ns clock: lines set while low, sampled at the rise (mode 0)
  task automatic pulse(input logic [1:0] d, input logic [1:0] e, output logic [1:0] s);
    drv = d;
    en = e;
    tick(8);
    sck = 1'b1;
    s = lines;
    tick(8);
    sck = 1'b0;
  endtask

  // opcode and single-line fields on line zero
  task automatic send8(input logic [7:0] b);
    logic [1:0] s;
    for (int i = 7; i >= 0; i--) begin
      pulse({1'b0, b[i]}, 2'h1, s);
    end
  endtask

  // address as pairs, odd bit on line one
  task automatic send_pairs(input logic [23:0] a);
    logic [1:0] s;
    for (int i = 11; i >= 0; i--) begin
      pulse(a[2*i+:2], 2'h3, s);
    end
  endtask

  // lines released for dummy and data clocks
  task automatic recv_dual(input int n, output logic [7:0] b);
    logic [1:0] s;
    b = 8'h00;
    for (int i = 0; i < n; i++) begin
      pulse(2'h0, 2'h0, s);
      b = {b[5:0], s};
    end
  endtask

  // status byte comes back on line one, msb first
  task automatic recv_one(output logic [7:0] b);
    logic [1:0] s;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      pulse(2'h0, 2'h0, s);
      b = {b[6:0], s[1]};
    end
  endtask

  // instruction with no address or data
  task automatic command(input logic [7:0] op);
    select();
    send8(op);
    deselect();
  endtask
endmodule
`default_nettype wire

//--- bench/spi_flash_cmd_engine_bench.sv
// self-checking bench of the flash command engine with its host model
`default_nettype none
module spi_flash_cmd_engine_bench import flash_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic prog_ready;
  logic [7:0] block_protect;
  logic [7:0] mem_data;
  logic [1:0] fl = 2'h0;
  logic sck, chip_en_n, out0, oe0, out1, oe1, prog_valid, status_busy, latch;
  logic [1:0] drv, en;
  wire logic [1:0] lines;
  logic [18:0] mem_rd_addr;
  prog_word_s prog_word;
  erase_cmd_s erase_cmd, erase_last;
  prog_word_s words[$];
  int n_fail = 0;
  int comparisons = 0;
  int erase_seen = 0;

  always #5 clk_sys = ~clk_sys;

  // released lines show the inverse of their last level, never a held value
  always @(posedge clk_sys) fl <= ~lines;
  assign lines[0] = (oe0 && en[0]) ? 1'bx : oe0 ? out0 : en[0] ? drv[0] : fl[0];
  assign lines[1] = (oe1 && en[1]) ? 1'bx : oe1 ? out1 : en[1] ? drv[1] : fl[1];

  // array contents: a fixed mix of address bits
  function automatic logic [7:0] mem_val(input logic [18:0] a);
    return a[7:0] ^ a[18:11] ^ 8'h5A;
  endfunction

  // array read port answers in the same cycle as the address
  assign mem_data = mem_val(mem_rd_addr);

  // record array requests at the edge they are taken
  always @(posedge clk_sys) begin
    if (prog_valid && prog_ready) words.push_back(prog_word);
    if (erase_cmd.req === 1'b1) begin
      erase_seen++;
      erase_last = erase_cmd;
    end
  end

  spi_flash_cmd_engine #(
    .PAGE_PROGRAM_CYCLES(40),
    .SECTOR_ERASE_CYCLES(40),
    .BLOCK_ERASE_CYCLES(40),
    .FULL_ERASE_CYCLES(600)
  ) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .sck(sck), .chip_en_n(chip_en_n),
    .serial_line_zero_in(lines[0]), .serial_line_zero_out(out0), .serial_line_zero_oe(oe0),
    .serial_line_one_in(lines[1]), .serial_line_one_out(out1), .serial_line_one_oe(oe1),
    .block_protect(block_protect), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_data), .prog_word(prog_word), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .erase_cmd(erase_cmd), .status_busy(status_busy),
    .write_enable_latch(latch)
  );

  spi_host_model u_host (
    .clk_sys(clk_sys), .sck(sck), .chip_en_n(chip_en_n), .drv(drv), .en(en), .lines(lines)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic head(input logic [7:0] op, input logic [23:0] a);
    u_host.select();
    u_host.send8(op);
    u_host.send8(a[23:16]);
    u_host.send8(a[15:8]);
    u_host.send8(a[7:0]);
  endtask

  task automatic read_status(output logic [7:0] a, output logic [7:0] b);
    u_host.select();
    u_host.send8(8'h05);
    u_host.recv_one(a);
    u_host.recv_one(b);
    u_host.deselect();
  endtask

  // poll busy with a bound; the latch drops with it
  task automatic wait_idle();
    for (int i = 0; i < 3000 && status_busy !== 1'b0; i++) u_host.tick(1);
    check(status_busy, 1'b0);
    check(latch, 1'b0);
  endtask

  task automatic t_status();
    logic [7:0] a, b;
    read_status(a, b);
    check({a, b}, 16'h0000);
    u_host.command(8'h06);
    check(latch, 1'b1);
    read_status(a, b);
    check({a, b}, 16'h0202);
    u_host.command(8'h04);
    check(latch, 1'b0);
    head(8'h20, 24'h010000);
    u_host.deselect();
    check(erase_seen, 0);
    u_host.command(8'h06);
    u_host.select();
    u_host.send8(8'h01);
    u_host.send8(8'h00);
    u_host.deselect();
    check(latch, 1'b0);
    $display("status and latch test done");
  endtask

  task automatic t_dual_out();
    logic [7:0] b;
    head(8'h3B, 24'h07FFFE);
    u_host.send8(8'h00);
    for (int i = 0; i < 3; i++) begin
      u_host.recv_dual(4, b);
      check(b, mem_val(19'h7FFFE + 19'(i)));
    end
    u_host.deselect();
    check({oe1, oe0}, 2'h0);
    $display("dual output read test done");
  endtask

  task automatic t_dual_io();
    logic [7:0] b;
    u_host.select();
    u_host.send8(8'hBB);
    u_host.send_pairs(24'h05A5A5);
    u_host.recv_dual(4, b);
    for (int i = 0; i < 2; i++) begin
      u_host.recv_dual(4, b);
      check(b, mem_val(19'h5A5A5 + 19'(i)));
    end
    u_host.deselect();
    check({oe1, oe0}, 2'h0);
    $display("dual io read test done");
  endtask

  // column wraps in the page, partial bits dropped, protected block ignored
  task automatic t_program();
    logic [1:0] s;
    u_host.command(8'h06);
    head(8'h02, 24'h0001FE);
    u_host.send8(8'h11);
    u_host.send8(8'h22);
    u_host.send8(8'h33);
    for (int i = 0; i < 3; i++) u_host.pulse(2'h1, 2'h1, s);
    u_host.deselect();
    check(status_busy, 1'b1);
    u_host.tick(300);
    prog_ready = 1'b1;
    wait_idle();
    check(words.size(), 3);
    check(words[0], {19'h00100, 8'h33});
    check(words[1], {19'h001FE, 8'h11});
    check(words[2], {19'h001FF, 8'h22});
    words.delete();
    block_protect = 8'h01;
    u_host.command(8'h06);
    head(8'h02, 24'h000010);
    u_host.send8(8'h44);
    u_host.deselect();
    u_host.tick(60);
    check({status_busy, 8'(words.size())}, 9'h000);
    u_host.command(8'h04);
    block_protect = 8'h00;
    $display("page program test done");
  endtask

  task automatic t_erase();
    logic [7:0] ops [5] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
    logic [1:0] kinds [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    logic [7:0] a, b;
    int n;
    // extra address bits after a chip erase opcode are ignored
    for (int i = 0; i < 5; i++) begin
      u_host.command(8'h06);
      n = erase_seen;
      head(ops[i], 24'h034567);
      u_host.deselect();
      check(erase_seen - n, 1);
      check(erase_last.kind, kinds[i]);
      check(status_busy, 1'b1);
      if (kinds[i] == 2'h0) check(erase_last.addr, 19'h34000);
      if (kinds[i] == 2'h1) check(erase_last.addr, 19'h30000);
      if (kinds[i] == 2'h2) begin
        read_status(a, b);
        check({a, b}, 16'h0303);
      end
      wait_idle();
    end
    block_protect = 8'h08;
    for (int i = 0; i < 5; i += 2) begin
      u_host.command(8'h06);
      n = erase_seen;
      head(ops[i], 24'h034567);
      u_host.deselect();
      check(erase_seen - n, 0);
      u_host.command(8'h04);
    end
    block_protect = 8'h00;
    $display("erase test done");
  endtask

  // hang guard: far beyond the expected length of all tests
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] t=%0t seen=%h want=%h", $time, 1'b0, 1'b1);
    conclude();
  end

  initial begin
    prog_ready = 1'b0;
    block_protect = 8'h00;
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    u_host.tick(4);
    t_status();
    t_dual_out();
    t_dual_io();
    t_program();
    t_erase();
    conclude();
  end
endmodule
`default_nettype wire
